// [verilog/lcd_pkg.sv]
// Contract
// - one-fifth duty alternates at 25, 51 or 102 Hz; port option stops alternation.
// - drivable segments scale with duty: 24, 48, 72, 96, 120.
// - segment pins one to twelve may be CMOS or P open-drain static ports.
// - static port pins keep their value in stop mode and display off.
// - decoder inputs 0 to 4 give the documented eight-line patterns.
// - decoder inputs 5, 6, 8, 9 and 7 patterns; A to F give zeros.
// - line f for digit seven is fixed by a mask option.
// - plain and blanking decoded loads both pass the nibble through the decoder.
// - blanking decoded load of zero forces all eight lines low.
// - pair load bypasses decoder: working nibble to a-d, accumulator to e-h.
// - table load bypasses decoder: table byte bits 0-7 drive lines a-h.
// - four-bit latch select field decodes to one of sixteen strobes.
// - each latch takes data from one line and clock from one strobe.
// - routing array assigns 120 of 128 line-strobe pairs, freely per latch.
// - each segment pin owns one latch per common, five commons.
// - output multiplexer scans latches per mask duty: static to one-fifth.
// - display off blanks commons and non-port segments, keeps latches; latches stay writable.
// - in stop state every common and non-port segment output goes to ground.
package lcd_pkg;

	localparam int CLOCK_HZ = 50_000_000;
	localparam int NUM_SEG = 24;
	localparam int NUM_COM = 5;
	localparam int NUM_LATCH = 120;
	localparam int NUM_LINES = 8;
	localparam int NUM_STROBES = 16;
	localparam int NUM_DC_PINS = 12;

	// mask duty option codes
	localparam logic [2:0] DUTY_STATIC = 3'h0;
	localparam logic [2:0] DUTY_HALF = 3'h1;
	localparam logic [2:0] DUTY_THIRD = 3'h2;
	localparam logic [2:0] DUTY_QUARTER = 3'h3;
	localparam logic [2:0] DUTY_FIFTH = 3'h4;

	// mask frame frequency option codes
	localparam logic [1:0] SPEED_SLOW = 2'h0;
	localparam logic [1:0] SPEED_TYPICAL = 2'h1;
	localparam logic [1:0] SPEED_FAST = 2'h2;
	localparam logic [1:0] SPEED_PORT = 2'h3;

	// per-pin static port option
	localparam logic [1:0] DC_NONE = 2'h0;
	localparam logic [1:0] DC_CMOS = 2'h1;
	localparam logic [1:0] DC_OPEN_DRAIN = 2'h2;

	// load operation codes
	localparam logic [1:0] OP_PLAIN = 2'h0;
	localparam logic [1:0] OP_BLANK = 2'h1;
	localparam logic [1:0] OP_PAIR = 2'h2;
	localparam logic [1:0] OP_TABLE = 2'h3;

	// register byte offsets
	localparam logic [3:0] REG_LOAD = 4'h0;
	localparam logic [3:0] REG_CTRL = 4'h4;
	localparam logic [3:0] REG_STATUS = 4'h8;
	localparam logic [3:0] REG_LINES = 4'hC;

	// field positions
	localparam int LOAD_OP_LSB = 0;
	localparam int LOAD_SEL_LSB = 4;
	localparam int LOAD_WORK_LSB = 8;
	localparam int LOAD_ACC_LSB = 12;
	localparam int LOAD_TABLE_LSB = 16;
	localparam int LOAD_WIDTH = 24;
	localparam int CTRL_OFF_BIT = 0;
	localparam int STAT_OFF_BIT = 0;
	localparam int STAT_STOP_BIT = 1;
	localparam int STAT_COM_LSB = 2;
	localparam int STAT_PHASE_BIT = 5;

	// decoder patterns, bit 0 is line a
	localparam logic [7:0] SEG_BLANK = 8'h00;
	localparam logic [7:0] SEG_F_LINE = 8'h20;
	localparam logic [15:0][7:0] SEG_TABLE = {
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hEF, 8'hFF,
		8'h87, 8'hFD, 8'hED, 8'hE6, 8'hCF, 8'hDB, 8'h86, 8'hBF
	};
	localparam logic [3:0] DIGIT_SEVEN = 4'h7;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;

	typedef logic [NUM_LATCH-1:0][2:0] line_map_t;
	typedef logic [NUM_LATCH-1:0][3:0] strobe_map_t;
	typedef logic [NUM_DC_PINS-1:0][1:0] dc_map_t;

	function automatic int com_count(input logic [2:0] duty);
		return int'(duty) + 1;
	endfunction

	// alternating frequency in Hz per duty and speed
	function automatic int alt_hz(input logic [2:0] duty, input logic [1:0] speed);
		int hz;
		hz = 0;
		unique case (duty)
			DUTY_STATIC: hz = (speed == SPEED_FAST) ? 64 : 32;
			DUTY_THIRD: hz = (speed == SPEED_SLOW) ? 21 : (speed == SPEED_TYPICAL) ? 42 : 85;
			DUTY_FIFTH: hz = (speed == SPEED_SLOW) ? 25 : (speed == SPEED_TYPICAL) ? 51 : 102;
			default: hz = (speed == SPEED_SLOW) ? 16 : (speed == SPEED_TYPICAL) ? 32 : 64;
		endcase
		return (speed == SPEED_PORT) ? 0 : hz;
	endfunction

	// cycles per common slot; two frames make one alternation period
	function automatic int slot_cycles(input logic [2:0] duty, input logic [1:0] speed);
		int hz;
		hz = alt_hz(duty, speed);
		return (hz == 0) ? 1 : CLOCK_HZ / (2 * hz * com_count(duty));
	endfunction

	function automatic line_map_t default_lines();
		line_map_t m;
		for (int k = 0; k < NUM_LATCH; k++) begin
			m[k] = 3'(k % NUM_LINES);
		end
		return m;
	endfunction

	function automatic strobe_map_t default_strobes();
		strobe_map_t m;
		for (int k = 0; k < NUM_LATCH; k++) begin
			m[k] = 4'(k / NUM_LINES);
		end
		return m;
	endfunction

endpackage

// [verilog/lcd_line_source.sv]
`timescale 1ns/1ps
`default_nettype none
// selects what drives the eight data lines for one load
module lcd_line_source #(
	parameter logic F_ON_SEVEN = 1'b1
) (
	input wire logic [1:0] op,
	input wire logic [3:0] work_nibble,
	input wire logic [3:0] accumulator_nibble,
	input wire logic [7:0] indexed_table_byte,
	output logic [7:0] lines
);

	logic [7:0] decoded;

	always_comb begin
		decoded = lcd_pkg::SEG_TABLE[work_nibble];
		if (work_nibble == lcd_pkg::DIGIT_SEVEN) begin
			decoded = F_ON_SEVEN ? (decoded | lcd_pkg::SEG_F_LINE) : decoded;
		end
		unique case (op)
			lcd_pkg::OP_PLAIN: lines = decoded;
			lcd_pkg::OP_BLANK: begin
				// zero blanks so leading zero digits vanish
				lines = (work_nibble == lcd_pkg::DIGIT_ZERO) ? lcd_pkg::SEG_BLANK : decoded;
			end
			lcd_pkg::OP_PAIR: lines = {accumulator_nibble, work_nibble};
			lcd_pkg::OP_TABLE: lines = indexed_table_byte;
		endcase
	end

endmodule
`default_nettype wire

// [verilog/lcd_segment_latch_driver.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_segment_latch_driver #(
	parameter logic [2:0] DUTY = lcd_pkg::DUTY_FIFTH,
	parameter logic [1:0] SPEED = lcd_pkg::SPEED_TYPICAL,
	parameter logic F_ON_SEVEN = 1'b1,
	parameter logic RESET_LIT = 1'b0,
	parameter lcd_pkg::dc_map_t DC_MODE = '0,
	parameter lcd_pkg::line_map_t LATCH_LINE = lcd_pkg::default_lines(),
	parameter lcd_pkg::strobe_map_t LATCH_STROBE = lcd_pkg::default_strobes(),
	parameter int SLOT_CYCLES = lcd_pkg::slot_cycles(DUTY, SPEED)
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic stop_mode,
	output logic [lcd_pkg::NUM_COM-1:0] com_out,
	output logic [lcd_pkg::NUM_COM-1:0] com_active,
	output logic [lcd_pkg::NUM_SEG-1:0] seg_out,
	output logic [lcd_pkg::NUM_SEG-1:0] seg_oe
);

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_e;

	typedef struct packed {
		bus_e bus;
		logic waitrequest;
		logic [31:0] readdata;
		logic [lcd_pkg::LOAD_WIDTH-1:0] last_load;
		logic display_off;
		logic [7:0] lines;
		logic [lcd_pkg::NUM_STROBES-1:0] latch_strobe;
		logic [lcd_pkg::NUM_LATCH-1:0] latch;
		logic [2:0] com;
		logic phase;
		logic [31:0] slot_count;
		logic [lcd_pkg::NUM_COM-1:0] com_out;
		logic [lcd_pkg::NUM_COM-1:0] com_active;
		logic [lcd_pkg::NUM_SEG-1:0] seg_out;
		logic [lcd_pkg::NUM_SEG-1:0] seg_oe;
	} state_s;

	localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYCLES - 1);
	localparam logic [2:0] COM_LAST = 3'(lcd_pkg::com_count(DUTY) - 1);
	localparam logic FRAME_RUNS = (SPEED != lcd_pkg::SPEED_PORT);

	state_s state;
	state_s next_state;

	logic [7:0] source_lines;
	logic [lcd_pkg::LOAD_WIDTH-1:0] load_word;

	assign load_word = avs_writedata[lcd_pkg::LOAD_WIDTH-1:0];

	// ------------------------------------------------------------
	// data line source
	// ------------------------------------------------------------

	lcd_line_source #(
		.F_ON_SEVEN(F_ON_SEVEN)
	) line_source (
		.op(load_word[lcd_pkg::LOAD_OP_LSB +: 2]),
		.work_nibble(load_word[lcd_pkg::LOAD_WORK_LSB +: 4]),
		.accumulator_nibble(load_word[lcd_pkg::LOAD_ACC_LSB +: 4]),
		.indexed_table_byte(load_word[lcd_pkg::LOAD_TABLE_LSB +: 8]),
		.lines(source_lines)
	);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	function automatic int latch_index(input int pin, input int com);
		return pin * lcd_pkg::NUM_COM + com;
	endfunction

	function automatic logic [31:0] status_word(input state_s s, input logic stop);
		logic [31:0] w;
		w = '0;
		w[lcd_pkg::STAT_OFF_BIT] = s.display_off;
		w[lcd_pkg::STAT_STOP_BIT] = stop;
		w[lcd_pkg::STAT_COM_LSB +: 3] = s.com;
		w[lcd_pkg::STAT_PHASE_BIT] = s.phase;
		return w;
	endfunction

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------

	always_comb begin
		logic blank;
		logic lit;
		logic dc_value;
		blank = 1'b0;
		lit = 1'b0;
		dc_value = 1'b0;
		next_state = state;
		// a strobe lives for exactly one cycle
		next_state.latch_strobe = '0;

		// latches clocked by the strobe take their routed line
		for (int k = 0; k < lcd_pkg::NUM_LATCH; k++) begin
			if (state.latch_strobe[LATCH_STROBE[k]]) begin
				next_state.latch[k] = state.lines[LATCH_LINE[k]];
			end
		end

		// bus slave: answer one cycle after the request is seen
		unique case (state.bus)
			BUS_IDLE: begin
				if (avs_read || avs_write) begin
					next_state.bus = BUS_ACK;
					next_state.waitrequest = 1'b0;
					unique case (avs_address)
						lcd_pkg::REG_LOAD: next_state.readdata = 32'(state.last_load);
						lcd_pkg::REG_CTRL: next_state.readdata = 32'(state.display_off);
						lcd_pkg::REG_STATUS: next_state.readdata = status_word(state, stop_mode);
						lcd_pkg::REG_LINES: next_state.readdata = 32'(state.lines);
						default: next_state.readdata = '0;
					endcase
				end
			end
			BUS_ACK: begin
				next_state.bus = BUS_IDLE;
				next_state.waitrequest = 1'b1;
				if (avs_write) begin
					if (avs_address == lcd_pkg::REG_LOAD) begin
						// latches stay writable whether or not the display is on
						next_state.last_load = load_word;
						next_state.lines = source_lines;
						next_state.latch_strobe = 16'h0001 << load_word[lcd_pkg::LOAD_SEL_LSB +: 4];
					end
					if (avs_address == lcd_pkg::REG_CTRL) begin
						next_state.display_off = avs_writedata[lcd_pkg::CTRL_OFF_BIT];
					end
				end
			end
		endcase

		// common scan timing; the port option holds the scan still
		if (FRAME_RUNS) begin
			if (state.slot_count == SLOT_LAST) begin
				next_state.slot_count = '0;
				if (state.com == COM_LAST) begin
					next_state.com = '0;
					next_state.phase = ~state.phase;
				end else begin
					next_state.com = state.com + 3'h1;
				end
			end else begin
				next_state.slot_count = state.slot_count + 32'h1;
			end
		end

		// ground commons and non-port segments in stop state or display off, latches untouched
		blank = stop_mode || state.display_off || !FRAME_RUNS;
		for (int c = 0; c < lcd_pkg::NUM_COM; c++) begin
			if (blank || c > int'(COM_LAST)) begin
				next_state.com_out[c] = 1'b0;
				next_state.com_active[c] = 1'b0;
			end else begin
				next_state.com_active[c] = (3'(c) == next_state.com);
				next_state.com_out[c] = (3'(c) == next_state.com) ? next_state.phase : ~next_state.phase;
			end
		end

		for (int p = 0; p < lcd_pkg::NUM_SEG; p++) begin
			// only latches of commons in use reach the pin, so segments scale with duty
			lit = next_state.latch[latch_index(p, int'(next_state.com))];
			next_state.seg_oe[p] = 1'b1;
			next_state.seg_out[p] = blank ? 1'b0 : (lit ? ~next_state.phase : next_state.phase);
			if (p < lcd_pkg::NUM_DC_PINS) begin
				// a static port shows its first latch and ignores stop and display off
				dc_value = next_state.latch[latch_index(p, 0)];
				if (DC_MODE[p] == lcd_pkg::DC_CMOS) begin
					next_state.seg_out[p] = dc_value;
				end else if (DC_MODE[p] == lcd_pkg::DC_OPEN_DRAIN) begin
					// p-type only pulls high; low is left to the board
					next_state.seg_out[p] = 1'b1;
					next_state.seg_oe[p] = dc_value;
				end
			end
		end
	end

	// ------------------------------------------------------------
	// register
	// ------------------------------------------------------------

	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			state.bus <= BUS_IDLE;
			state.waitrequest <= 1'b1;
			state.readdata <= '0;
			state.last_load <= '0;
			state.display_off <= 1'b0;
			state.lines <= '0;
			state.latch_strobe <= '0;
			state.latch <= {lcd_pkg::NUM_LATCH{RESET_LIT}};
			state.com <= '0;
			state.phase <= 1'b0;
			state.slot_count <= '0;
			state.com_out <= '0;
			state.com_active <= '0;
			state.seg_out <= '0;
			state.seg_oe <= '1;
		end else begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------

	assign avs_readdata = state.readdata;
	assign avs_waitrequest = state.waitrequest;
	assign com_out = state.com_out;
	assign com_active = state.com_active;
	assign seg_out = state.seg_out;
	assign seg_oe = state.seg_oe;

endmodule
`default_nettype wire

// [tb/lcd_drv_props.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_drv_props #(
	parameter logic [2:0] DUTY = 3'h4,
	parameter lcd_pkg::dc_map_t DC_MODE = '0,
	parameter int SLOT_CYCLES = 4
) (
	input wire logic clock,
	input wire logic resetn,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic stop_mode,
	input wire logic [4:0] com_out,
	input wire logic [4:0] com_active,
	input wire logic [23:0] seg_out,
	input wire logic [23:0] seg_oe
);
	function automatic logic [23:0] pins(input logic [1:0] v);
		logic [23:0] m;
		m = '0;
		for (int i = 0; i < 12; i++) m[i] = DC_MODE[i] == v;
		return m;
	endfunction
	localparam logic [23:0] OD = pins(2'h2);
	localparam logic [23:0] DC = OD | pins(2'h1);
	// ----------------------------------------
	// slot tracking
	// ----------------------------------------
	// a slot that began after blanking may be partial, so only full slots are timed
	logic [4:0] prev;
	int run;
	logic full;
	wire logic chg = com_active != prev && com_active != '0 && prev != '0;
	always_ff @(posedge clock or negedge resetn) begin
		if (!resetn) begin
			prev <= '0;
			run <= 0;
			full <= 1'b0;
		end else begin
			prev <= com_active;
			run <= (com_active != prev) ? 0 : run + 1;
			full <= com_active != '0 && (chg || (com_active == prev && full));
		end
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!resetn);
	sequence s_off_taken;
		avs_write && !avs_waitrequest && avs_address == 4'h4 && avs_writedata[0];
	endsequence
	sequence s_blank;
		com_out == '0 && com_active == '0 && seg_out[23:12] == '0;
	endsequence
	a_stop_com: assert property (stop_mode && $past(stop_mode) |-> com_out == '0 && com_active == '0)
		else $error("commons not grounded in stop");
	a_stop_seg: assert property (stop_mode && $past(stop_mode) |-> seg_out[23:12] == '0)
		else $error("segments not grounded in stop");
	a_off_blank: assert property (s_off_taken |-> ##[1:3] s_blank)
		else $error("display off did not blank");
	a_scan_onehot: assert property ($onehot0(com_active))
		else $error("more than one common active");
	a_scan_order: assert property (chg |-> com_active == ((prev == 5'(1 << DUTY)) ? 5'h01 : prev << 1))
		else $error("commons scanned out of order");
	a_slot_len: assert property (chg && full |-> run == SLOT_CYCLES - 1)
		else $error("common slot length wrong");
	a_dc_level: assert property ($past(resetn) |-> (seg_out & OD) == OD && (seg_oe | OD) == '1)
		else $error("static port drive kind wrong");
	a_dc_hold: assert property ($rose(stop_mode) && $past(resetn) && $past(avs_waitrequest) &&
		$past(avs_waitrequest, 2) |=> $stable(seg_out & DC) && $stable(seg_oe & OD))
		else $error("static port changed on stop");
endmodule
bind lcd_segment_latch_driver lcd_drv_props #(.DUTY(DUTY), .DC_MODE(DC_MODE), .SLOT_CYCLES(SLOT_CYCLES)) i_props (
	.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
	.stop_mode(stop_mode), .com_out(com_out), .com_active(com_active), .seg_out(seg_out), .seg_oe(seg_oe));
`default_nettype wire

// [tb/lcd_panel_model.sv]
`timescale 1ns/1ps
`default_nettype none
module lcd_panel_model (
	input wire logic clock,
	input wire logic [4:0] com_out,
	input wire logic [4:0] com_active,
	input wire logic [23:0] seg_out,
	output logic [119:0] lit
);
	// a cell shows dark while segment and active common differ; it holds like glass between scans
	always @(posedge clock) begin
		for (int c = 0; c < 5; c++) begin
			for (int p = 0; p < 24; p++) begin
				if (com_active[c]) lit[p * 5 + c] <= seg_out[p] != com_out[c];
			end
		end
	end
endmodule
`default_nettype wire

// [tb/tb_lcd_segment_latch_driver.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_segment_latch_driver;
	// pin 0 push-pull port, pin 1 open-drain port
	localparam lcd_pkg::dc_map_t DCM = 24'h000009;
	localparam logic [119:0] PM = {{110{1'b1}}, 10'h000};
	logic clock = 1'b0;
	logic resetn = 1'b0;
	logic [3:0] avs_address = '0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = '0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic stop_mode = 1'b0;
	logic [4:0] com_out;
	logic [4:0] com_active;
	logic [23:0] seg_out;
	logic [23:0] seg_oe;
	logic [119:0] lit;
	logic [119:0] lat = '0;
	logic [31:0] q;
	int error_cnt = 0;
	int n_checks = 0;
	int cyc = 0;
	int seed = 19;
	int dec [16] = '{'hBF, 'h86, 'hDB, 'hCF, 'hE6, 'hED, 'hFD, 'hA7, 'hFF, 'hEF, 0, 0, 0, 0, 0, 0};
	// four-cycle slots override the typical speed, giving a 20-cycle frame
	lcd_segment_latch_driver #(.DC_MODE(DCM), .SLOT_CYCLES(4)) i_lcd_segment_latch_driver (
		.clock(clock), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .stop_mode(stop_mode), .com_out(com_out),
		.com_active(com_active), .seg_out(seg_out), .seg_oe(seg_oe));
	lcd_panel_model i_lcd_panel_model (.clock(clock), .com_out(com_out), .com_active(com_active),
		.seg_out(seg_out), .lit(lit));
	always #10 clock = ~clock;
	// ----------------------------------------
	// checking and bus tasks
	// ----------------------------------------
	task summarize;
		$display("checks %0d mismatches %0d", n_checks, error_cnt);
		if (error_cnt == 0 && n_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge clock) begin
		cyc++;
		if (cyc == 20000) begin
			error_cnt++;
			summarize();
		end
	end
	task chk(input string n, input logic [119:0] e, input logic [119:0] g);
		n_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		@(posedge clock);
		while (avs_waitrequest !== 1'b0) @(posedge clock);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task ld(input int op, input int s, input logic [7:0] w, input logic [7:0] t);
		int e;
		e = (op == 3) ? t : (op == 2) ? w : (op == 1 && w[3:0] == 0) ? 0 : dec[w[3:0]];
		bus(1, 4'h0, {8'h00, t, w, 4'(s), 2'h0, 2'(op)});
		bus(0, 4'hC, 0);
		chk("lines", e, q);
		for (int j = 0; j < 8; j++) if (s * 8 + j < 120) lat[s * 8 + j] = e[j];
	endtask
	task pnl(input string n);
		repeat (40) @(posedge clock);
		chk(n, lat & PM, lit & PM);
	endtask
	task dcc;
		chk("ports", {lat[5], lat[0], 1'b1}, {seg_oe[1], seg_out[0], seg_out[1]});
	endtask
	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		resetn <= 1'b1;
		bus(0, 4'h2, 0);
		chk("unmapped", 0, q);
		chk("rates", {32'd25, 32'd51, 32'd102, 32'd0}, {lcd_pkg::alt_hz(3'h4, 2'h0), lcd_pkg::alt_hz(3'h4, 2'h1),
			lcd_pkg::alt_hz(3'h4, 2'h2), lcd_pkg::alt_hz(3'h4, 2'h3)});
		for (int n = 0; n < 32; n++) ld(n / 16, n % 16, 8'(n % 16), 8'h00);
		bus(0, 4'h0, 0);
		chk("load word", 32'h00000FF1, q);
		pnl("decoded panel");
		$display("test decoded loads done");
		for (int n = 0; n < 8; n++) ld(2 + n % 2, {$random(seed)} % 16, 8'($random(seed)), 8'($random(seed)));
		pnl("direct panel");
		$display("test direct loads done");
		bus(1, 4'h4, 1);
		bus(0, 4'h4, 0);
		chk("ctrl", 1, q);
		repeat (4) @(posedge clock);
		chk("off pins", 0, {com_out, com_active, seg_out[23:12]});
		dcc();
		ld(3, 0, 8'h00, 8'($random(seed)));
		bus(0, 4'h8, 0);
		chk("status off", 1, q[0]);
		dcc();
		bus(1, 4'h4, 0);
		pnl("restored panel");
		$display("test display off done");
		stop_mode <= 1'b1;
		repeat (4) @(posedge clock);
		chk("stop pins", 0, {com_out, com_active, seg_out[23:12]});
		bus(0, 4'h8, 0);
		chk("status stop", 1, q[1]);
		dcc();
		stop_mode <= 1'b0;
		pnl("after stop");
		$display("test stop done");
		summarize();
	end
endmodule
`default_nettype wire
